/* shared/eeprom_prog_pkg.sv */
// constants and types of the serial eeprom command and program control
package eeprom_prog_pkg;
  // word and frame geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int OP_W   = 2;
  localparam int HDR_W  = OP_W + ADDR_W;
  localparam int CNT_W  = 5;
  localparam int WORDS  = 1 << ADDR_W;

  // opcodes following the start bit
  localparam logic [OP_W-1:0] OP_MISC  = 2'h0;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_READ  = 2'h2;
  localparam logic [OP_W-1:0] OP_ERASE = 2'h3;

  // top address bits telling the shared-opcode commands apart
  localparam logic [1:0] SUB_DISABLE   = 2'h0;
  localparam logic [1:0] SUB_FILL_ALL  = 2'h1;
  localparam logic [1:0] SUB_CLEAR_ALL = 2'h2;
  localparam logic [1:0] SUB_ENABLE    = 2'h3;

  // self-timed cycle: longest time, rounded down to whole clocks
  localparam int CLK_PERIOD_NS    = 5;
  localparam int PROG_TIME_MS     = 10;
  localparam int NS_PER_MS        = 1000000;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

  // control states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HEADER,
    ST_DATA,
    ST_ARMED,
    ST_READ,
    ST_IGNORE,
    ST_BUSY
  } ctrl_state_type;

  // pending array operation
  typedef enum logic [1:0] {
    ACT_WRITE,
    ACT_ERASE,
    ACT_CLEAR_ALL,
    ACT_FILL_ALL
  } prog_act_type;
endpackage : eeprom_prog_pkg

/* verilog/eeprom_prog_ctrl.sv */
// serial eeprom command decode, write protection and self-timed program cycle
// Summary of operation
// - select fall after a full write starts a self-timed clear-and-store.
// - self-timed cycles finish with no shift clock edges at all.
// - host may reselect during or after a cycle and poll status.
// - word program includes its own clear; no prior erase needed.
// - select fall after erase and address clears only that word.
// - erased word reads back all ones.
// - reset leaves program and erase disabled.
// - enabled state holds until reset or program disable.
// - while disabled every program or erase command leaves the array alone.
// - reads work whether programming is enabled or not.
// - select fall after clear-all sets every bit to one.
// - select fall after fill-all and data writes data everywhere.
// - fill-all needs no prior clear-all.
// - select falling outside that window starts no cycle.
// - status output low while busy, high when ready.
// - command, address and data sampled on rising shift clock.
// - frame is start bit one, opcode, address, then data.
// - dummy one on serial input floats the output at next clock fall.
module eeprom_prog_ctrl
  import eeprom_prog_pkg::*;
#(
  parameter int PROG_CYCLES = eeprom_prog_pkg::PROG_CYCLES_DFLT
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // serial pins from the host
  input  wire logic chip_select,
  input  wire logic shift_clock,
  input  wire logic serial_in,
  // serial output, three-state
  output logic      serial_out,
  output logic      serial_out_en
);
  import eeprom_prog_pkg::*;

  localparam int TIMER_W = $clog2(PROG_CYCLES + 1);

  // pin synchronisers
  logic cs_s1, cs_s2, cs_d;
  logic sk_s1, sk_s2, sk_d;
  logic di_s1, di_s2;
  logic sk_rise, sk_fall, cs_fall;

  // control state
  ctrl_state_type             state, next_state;
  prog_act_type               act, next_act;
  logic [CNT_W-1:0]           bit_cnt, next_bit_cnt;
  logic [HDR_W-1:0]           hdr, next_hdr, hdr_new;
  logic [DATA_W-1:0]          wdata, next_wdata;
  logic [DATA_W-1:0]          rd_shift, next_rd_shift;
  logic [TIMER_W-1:0]         timer, next_timer;
  logic                       prog_enabled, next_prog_enabled;
  logic                       status_on, next_status_on;
  logic                       hiz_pend, next_hiz_pend;
  logic                       next_serial_out, next_serial_out_en;
  logic                       commit;

  // nonvolatile array
  logic [DATA_W-1:0]          mem [WORDS];
  logic [DATA_W-1:0]          next_mem [WORDS];

  // two flops before any logic, third for edge finding
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_s1 <= 1'h0;
      cs_s2 <= 1'h0;
      cs_d  <= 1'h0;
      sk_s1 <= 1'h0;
      sk_s2 <= 1'h0;
      sk_d  <= 1'h0;
      di_s1 <= 1'h0;
      di_s2 <= 1'h0;
    end else begin
      cs_s1 <= chip_select;
      cs_s2 <= cs_s1;
      cs_d  <= cs_s2;
      sk_s1 <= shift_clock;
      sk_s2 <= sk_s1;
      sk_d  <= sk_s2;
      di_s1 <= serial_in;
      di_s2 <= di_s1;
    end
  end

  // edges of the synchronised pins
  assign sk_rise = sk_s2 & ~sk_d;
  assign sk_fall = ~sk_s2 & sk_d;
  assign cs_fall = ~cs_s2 & cs_d;
  assign commit  = (state == ST_BUSY) && (timer == '0);
  assign hdr_new = {hdr[HDR_W-2:0], di_s2};

  // next values of the command engine
  always_comb begin
    next_state         = state;
    next_act           = act;
    next_bit_cnt       = bit_cnt;
    next_hdr           = hdr;
    next_wdata         = wdata;
    next_rd_shift      = rd_shift;
    next_timer         = timer;
    next_prog_enabled  = prog_enabled;
    next_status_on     = status_on;
    next_hiz_pend      = hiz_pend;
    next_serial_out    = serial_out;
    unique case (state)
      ST_IDLE: begin
        if (cs_s2 && sk_rise && di_s2) begin
          next_state   = ST_HEADER;
          next_bit_cnt = '0;
        end
      end
      ST_HEADER: begin
        if (sk_rise) begin
          next_hdr     = hdr_new;
          next_bit_cnt = bit_cnt + CNT_W'(1);
          if (bit_cnt == CNT_W'(HDR_W - 1)) begin
            next_bit_cnt = '0;
            unique case (hdr_new[HDR_W-1 -: OP_W])
              OP_READ: begin
                next_rd_shift   = mem[hdr_new[ADDR_W-1:0]];
                next_serial_out = 1'h0;
                next_state      = ST_READ;
              end
              OP_WRITE: begin
                next_act   = ACT_WRITE;
                next_state = ST_DATA;
              end
              OP_ERASE: begin
                next_act   = ACT_ERASE;
                next_state = ST_ARMED;
              end
              OP_MISC: begin
                next_state = ST_IGNORE;
                unique case (hdr_new[ADDR_W-1 -: 2])
                  SUB_ENABLE:  next_prog_enabled = 1'h1;
                  SUB_DISABLE: next_prog_enabled = 1'h0;
                  SUB_CLEAR_ALL: begin
                    next_act   = ACT_CLEAR_ALL;
                    next_state = ST_ARMED;
                  end
                  SUB_FILL_ALL: begin
                    next_act   = ACT_FILL_ALL;
                    next_state = ST_DATA;
                  end
                endcase
              end
            endcase
          end
        end
      end
      ST_DATA: begin
        if (sk_rise) begin
          next_wdata   = {wdata[DATA_W-2:0], di_s2};
          next_bit_cnt = bit_cnt + CNT_W'(1);
          if (bit_cnt == CNT_W'(DATA_W - 1)) begin
            next_state = ST_ARMED;
          end
        end
      end
      ST_ARMED: begin
        if (sk_rise) begin
          next_state = ST_IGNORE;
        end
      end
      ST_READ: begin
        if (sk_rise) begin
          next_serial_out = rd_shift[DATA_W-1];
          next_rd_shift   = {rd_shift[DATA_W-2:0], 1'h0};
        end
      end
      ST_IGNORE: next_state = ST_IGNORE;
      ST_BUSY: begin
        // runs on the core clock alone, shift clock ignored
        next_timer = timer - TIMER_W'(1);
        if (commit) begin
          next_state     = ST_IDLE;
          next_status_on = 1'h1;
          next_hiz_pend  = 1'h0;
        end
      end
    endcase
    // select fall ends the frame, starting a cycle only when armed
    if (cs_fall && state != ST_BUSY) begin
      next_state = ST_IDLE;
      if (state == ST_ARMED) begin
        next_status_on = 1'h1;
        if (prog_enabled) begin
          next_state = ST_BUSY;
          next_timer = TIMER_W'(PROG_CYCLES - 1);
        end
      end
    end
    // status polling and its release by a dummy one
    if (status_on && cs_s2) begin
      next_serial_out = (state != ST_BUSY);
      if (sk_rise && di_s2) begin
        next_hiz_pend = 1'h1;
      end
      if (hiz_pend && sk_fall) begin
        next_status_on = 1'h0;
        next_hiz_pend  = 1'h0;
      end
    end
    next_serial_out_en = cs_s2 && (next_status_on || next_state == ST_READ);
  end

  // registers of the command engine, reset leaves writes disabled
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state         <= ST_IDLE;
      act           <= ACT_WRITE;
      bit_cnt       <= '0;
      hdr           <= '0;
      wdata         <= '0;
      rd_shift      <= '0;
      timer         <= '0;
      prog_enabled  <= 1'h0;
      status_on     <= 1'h0;
      hiz_pend      <= 1'h0;
      serial_out    <= 1'h0;
      serial_out_en <= 1'h0;
    end else begin
      state         <= next_state;
      act           <= next_act;
      bit_cnt       <= next_bit_cnt;
      hdr           <= next_hdr;
      wdata         <= next_wdata;
      rd_shift      <= next_rd_shift;
      timer         <= next_timer;
      prog_enabled  <= next_prog_enabled;
      status_on     <= next_status_on;
      hiz_pend      <= next_hiz_pend;
      serial_out    <= next_serial_out;
      serial_out_en <= next_serial_out_en;
    end
  end

  // array update at the end of the self-timed cycle
  always_comb begin
    for (int i = 0; i < WORDS; i++) begin
      next_mem[i] = mem[i];
      if (commit) begin
        unique case (act)
          ACT_CLEAR_ALL: next_mem[i] = {DATA_W{1'h1}};
          ACT_FILL_ALL:  next_mem[i] = wdata;
          default: begin
            if (i == int'(hdr[ADDR_W-1:0])) begin
              // auto clear folded into the store
              next_mem[i] = (act == ACT_WRITE) ? wdata : {DATA_W{1'h1}};
            end
          end
        endcase
      end
    end
  end

  // array storage, kept across reset
  always_ff @(posedge core_clk) begin
    mem <= next_mem;
  end

  // checks
  AST_ENABLE_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(prog_enabled) |-> $past(state == ST_HEADER && sk_rise && hdr_new[HDR_W-1 -: OP_W]
      == OP_MISC && hdr_new[ADDR_W-1 -: 2] == SUB_ENABLE))
    else $error("enable set without enable command");
  AST_DISABLE_CAUSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(prog_enabled) |-> $past(state == ST_HEADER && hdr_new[ADDR_W-1 -: 2] == SUB_DISABLE))
    else $error("enable cleared without disable command");
  AST_REFUSE: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_ARMED && cs_fall && !prog_enabled |=> state == ST_IDLE && status_on)
    else $error("cycle started while disabled");
  AST_START: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_ARMED && cs_fall && prog_enabled |=> state == ST_BUSY
      && timer == TIMER_W'(PROG_CYCLES - 1))
    else $error("armed command did not start cycle");
  AST_SELF_TIMED: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_BUSY && timer != '0 |=> state == ST_BUSY && timer == $past(timer) - TIMER_W'(1))
    else $error("self-timed cycle left early");
  AST_WINDOW: assert property (@(posedge core_clk) disable iff (!rst_b)
    state == ST_ARMED && sk_rise && !cs_fall |=> state == ST_IGNORE ##1 !(state == ST_BUSY))
    else $error("late select fall still armed");
  AST_BUSY_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b)
    status_on && cs_s2 && state == ST_BUSY |=> !serial_out)
    else $error("status not low while busy");
  AST_FLOAT: assert property (@(posedge core_clk) disable iff (!rst_b)
    status_on && hiz_pend && cs_s2 && sk_fall && state != ST_READ |=> !serial_out_en)
    else $error("output not released after dummy one");
  AST_STORE: assert property (@(posedge core_clk) disable iff (!rst_b)
    commit && act == ACT_ERASE |=> mem[hdr[ADDR_W-1:0]] == {DATA_W{1'h1}})
    else $error("erased word not all ones");
endmodule : eeprom_prog_ctrl

/* dv/serial_host_model.sv */
// host model driving the select, shift clock and serial data pins
module serial_host_model (
  // core clock and device outputs
  input  wire logic        core_clk,
  input  wire logic        serial_out,
  input  wire logic        serial_out_en,
  // pins towards the device
  output logic             chip_select,
  output logic             shift_clock,
  output logic             serial_in,
  // captured result and its toggle
  output logic [15:0]      res_word,
  output logic             res_flag = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle low from time zero
  initial begin
    chip_select = 1'b0;
    shift_clock = 1'b0;
    serial_in   = 1'b0;
  end
  // waits whole core cycles, ending on a falling edge
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  // one shift period of about 65 ns, bit set while low
  task automatic clk_rise(input logic b);
    serial_in = b;
    idle(7);
    shift_clock = 1'b1;
    idle(6);
    shift_clock = 1'b0;
  endtask : clk_rise
  // selects and shifts n bits msb first
  task automatic send(input int n, input logic [31:0] v);
    chip_select = 1'b1;
    idle(4);
    for (int i = n - 1; i >= 0; i--) clk_rise(v[i]);
  endtask : send
  // deselects before the next rise, then keeps select low
  task automatic end_frame();
    idle(2);
    chip_select = 1'b0;
    serial_in   = ~serial_in; // released line shows no stale value
    idle(8);
  endtask : end_frame
  // hands a result to the watcher
  task automatic publish(input logic [15:0] w);
    res_word = w;
    res_flag = ~res_flag;
  endtask : publish
  // read header, then sixteen bits sampled late in each period
  task automatic read(input logic [8:0] hdr);
    logic [15:0] w;
    w = '0;
    send(9, {23'h0, hdr});
    for (int i = 0; i < 16; i++) begin
      clk_rise(1'b0);
      w = {w[14:0], serial_out};
    end
    publish(w);
    end_frame();
  endtask : read
  // status poll, then a dummy one to float the output
  task automatic poll();
    logic [2:0] s;
    chip_select = 1'b1;
    idle(6);
    s[1:0] = {serial_out_en, serial_out};
    clk_rise(1'b1);
    idle(6);
    s[2] = serial_out_en;
    publish({13'h0, s});
    end_frame();
  endtask : poll
endmodule : serial_host_model

/* dv/tb_eeprom_prog_ctrl.sv */
// self-checking bench for the serial eeprom program control
module tb_eeprom_prog_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import eeprom_prog_pkg::*;
  localparam int PROG = 400;
  logic        core_clk = 1'b0;
  logic        rst_b    = 1'b0;
  logic        chip_select, shift_clock, serial_in, serial_out, serial_out_en, res_flag;
  logic [15:0] res_word, d1, d2, d3;
  logic [5:0]  a1, a2;
  logic [15:0] exp_q[$];
  int          bad_count = 0;
  int          tests_run = 0;
  // 200 MHz core clock
  initial forever #2.5 core_clk = ~core_clk;
  // device with a short self-timed cycle
  eeprom_prog_ctrl #(.PROG_CYCLES(PROG)) u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .chip_select(chip_select), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_en(serial_out_en));
  // host side partner
  serial_host_model u_host (.core_clk(core_clk), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .chip_select(chip_select), .shift_clock(shift_clock),
    .serial_in(serial_in), .res_word(res_word), .res_flag(res_flag));
  // sends one command frame, optionally with one extra late rise
  task automatic do_cmd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                        input logic late);
    int n;
    n = (op == OP_WRITE || (op == OP_MISC && a[5:4] == SUB_FILL_ALL)) ? 25 : 9;
    u_host.send(n, (n == 25) ? {7'h0, 1'b1, op, a, d} : {23'h0, 1'b1, op, a});
    if (late) u_host.clk_rise(1'b0);
    u_host.end_frame();
  endtask : do_cmd
  // notes the expected word, then reads it
  task automatic chk_read(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host.read({1'b1, OP_READ, a});
  endtask : chk_read
  // notes the expected status, then polls
  task automatic chk_poll(input logic rdy);
    exp_q.push_back({15'h1, rdy});
    u_host.poll();
  endtask : chk_poll
  // lets a self-timed cycle run out
  task automatic wait_cycle();
    u_host.idle(PROG + 40);
  endtask : wait_cycle
  // compares each result with the oldest note
  always @(res_flag) begin
    logic [15:0] e;
    e = 'x;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    tests_run++;
    if (res_word !== e) begin
      bad_count++;
      $display("mismatch result expected %h seen %h", e, res_word);
    end
  end
  // prints the counts and the verdict
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // cuts a hang short
  initial begin
    #400us;
    bad_count++;
    $display("mismatch watchdog expected finish seen timeout");
    tally_and_finish();
  end
  // main sequence
  initial begin
    void'($urandom(34));
    {d1, d2, d3} = 48'({$urandom, $urandom});
    a1 = 6'($urandom);
    a2 = ~a1;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    u_host.idle(4);
    do_cmd(OP_WRITE, a1, d1, 1'b0);
    chk_poll(1'b1);
    $display("test power-up protection done");
    do_cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 16'h0, 1'b0);
    do_cmd(OP_WRITE, a1, d1, 1'b0);
    chk_poll(1'b0);
    wait_cycle();
    chk_poll(1'b1);
    chk_read(a1, d1);
    do_cmd(OP_WRITE, a1, d2, 1'b0);
    do_cmd(OP_ERASE, a1, 16'h0, 1'b0);
    wait_cycle();
    chk_read(a1, d2);
    $display("test program done");
    do_cmd(OP_WRITE, a2, d3, 1'b0);
    wait_cycle();
    do_cmd(OP_ERASE, a1, 16'h0, 1'b0);
    wait_cycle();
    chk_read(a1, 16'hFFFF);
    chk_read(a2, d3);
    do_cmd(OP_WRITE, a2, d1, 1'b1);
    // select drops one data bit early, frame must be dropped
    u_host.send(24, {8'h0, 1'b1, OP_WRITE, a2, d1[15:1]});
    u_host.end_frame();
    chk_read(a2, d3);
    $display("test erase and window done");
    do_cmd(OP_MISC, {SUB_FILL_ALL, 4'h0}, d1, 1'b0);
    wait_cycle();
    chk_read(a1, d1);
    chk_read(a2, d1);
    do_cmd(OP_MISC, {SUB_CLEAR_ALL, 4'h0}, 16'h0, 1'b0);
    wait_cycle();
    chk_read(a2, 16'hFFFF);
    $display("test whole array done");
    do_cmd(OP_MISC, {SUB_DISABLE, 4'h0}, 16'h0, 1'b0);
    do_cmd(OP_WRITE, a1, d2, 1'b0);
    chk_poll(1'b1);
    do_cmd(OP_MISC, {SUB_FILL_ALL, 4'h0}, d2, 1'b0);
    chk_poll(1'b1);
    chk_read(a1, 16'hFFFF);
    $display("test disabled done");
    // mid-run reset after enable must leave writes disabled
    do_cmd(OP_MISC, {SUB_ENABLE, 4'h0}, 16'h0, 1'b0);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    u_host.idle(4);
    do_cmd(OP_WRITE, a1, d2, 1'b0);
    chk_poll(1'b1);
    chk_read(a1, 16'hFFFF);
    $display("test reset protection done");
    tally_and_finish();
  end
endmodule : tb_eeprom_prog_ctrl
